// ==== hw/pe_regs.sv ====
// pe_regs: performance enhancement extension register set, the card's
// side. byte reads and writes arrive from the extension register command
// decoder; feature enables and start pulses go to the card's engines.
// assumes all inputs are on the core clock; support values are steady.
`default_nettype none

module pe_regs
	import pe_pkg::*;
#(
	parameter int unsigned BOUND_CYCLES = PE_BOUND_CYCLES
)
(
	input wire logic clock,
	input wire logic rst,
	// byte access from the extension register command decoder
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic [8:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	output logic [7:0] acc_rdata_q,
	output logic acc_rvalid_q,
	// capabilities of the card
	input wire logic evt_supported,
	input wire logic card_maint_supported,
	input wire logic host_maint_supported,
	input wire logic cache_supported,
	input wire logic [1:0] maint_urgency,
	input wire logic [7:0] queue_depth_code,
	// task error reporting from the queue logic
	input wire logic [31:0] task_err_set,
	input wire logic [31:0] task_err_clr,
	// engine feedback and power-off notice
	input wire logic maint_broken,
	input wire logic flush_finished,
	input wire logic poweroff_notified,
	// controls to the engines
	output logic card_event_report_en_q,
	output logic card_maint_en_q,
	output logic host_maint_en_q,
	output logic cache_en_q,
	output logic command_queue_en_q,
	output logic command_queue_seq_q,
	output logic maint_start_q,
	output logic maint_stop_q,
	output logic flush_start_q,
	output logic flush_stop_q
);

	// control state
	logic evt_en_d;
	logic cmaint_en_d;
	logic hmaint_en_d;
	logic cache_en_d;
	logic cq_en_d;
	logic cq_seq_d;
	logic maint_trg_q;
	logic maint_trg_d;
	logic flush_trg_q;
	logic flush_trg_d;
	logic off_q;
	logic [31:0] maint_cnt_q;
	logic [31:0] flush_cnt_q;
	pe_trg_e maint_st_q;
	pe_trg_e flush_st_q;
	logic maint_eng_q;
	logic flush_eng_q;

	// read pipeline
	logic rd1_q;
	logic [8:0] addr1_q;
	logic [7:0] task_byte;
	logic [7:0] rd_byte;

	// write decode
	logic wr_ok;
	logic wr_evt;
	logic wr_menable;
	logic wr_mtrig;
	logic wr_cache;
	logic wr_flush;
	logic wr_queue;
	logic maint_set;
	logic flush_set;
	logic maint_timeout;
	logic flush_timeout;
	logic maint_clear;
	logic flush_clear;

	// support half is read-only, writes after power-off are dropped
	assign wr_ok = acc_wr && acc_addr[PE_CTRL_BIT] && !off_q;
	assign wr_evt = wr_ok && (acc_addr == PE_OFS_EVT_ENABLE);
	assign wr_menable = wr_ok && (acc_addr == PE_OFS_MAINT_ENABLE);
	assign wr_mtrig = wr_ok && (acc_addr == PE_OFS_MAINT_TRIGGER);
	assign wr_cache = wr_ok && (acc_addr == PE_OFS_CACHE_ENABLE);
	assign wr_flush = wr_ok && (acc_addr == PE_OFS_FLUSH_TRIGGER);
	assign wr_queue = wr_ok && (acc_addr == PE_OFS_QUEUE_CONTROL);

	assign evt_en_d = wr_evt ? acc_wdata[PE_BIT_ENABLE]
		: card_event_report_en_q;
	// maintenance enables, reserved bits never stored
	assign cmaint_en_d = wr_menable ? acc_wdata[PE_BIT_CARD_MAINT]
		: card_maint_en_q;
	assign hmaint_en_d = wr_menable ? acc_wdata[PE_BIT_HOST_MAINT]
		: host_maint_en_q;
	assign cache_en_d = wr_cache ? acc_wdata[PE_BIT_ENABLE] : cache_en_q;
	assign cq_en_d = wr_queue ? acc_wdata[PE_BIT_QUEUE_EN]
		: command_queue_en_q;
	assign cq_seq_d = wr_queue ? acc_wdata[PE_BIT_QUEUE_SEQ]
		: command_queue_seq_q;

	// a host write of 1 starts; a host write of 0 does not stop anything
	assign maint_set = wr_mtrig && acc_wdata[PE_BIT_TRIGGER];
	assign flush_set = wr_flush && acc_wdata[PE_BIT_TRIGGER];

	// force the break if the engine has not reported in time
	assign maint_timeout = maint_trg_q && (maint_cnt_q >= BOUND_CYCLES - 1);
	assign flush_timeout = flush_trg_q && (flush_cnt_q >= BOUND_CYCLES - 1);

	// card clears the bit when maintenance breaks off
	assign maint_clear = maint_broken || maint_timeout;
	// card clears the bit when the flush is finished
	assign flush_clear = flush_finished || flush_timeout;

	// a new start in the clearing cycle wins; the bit stays set and no start or stop pulse goes out
	assign maint_trg_d = maint_set ? 1'b1
		: (maint_clear ? 1'b0 : maint_trg_q);
	assign flush_trg_d = flush_set ? 1'b1
		: (flush_clear ? 1'b0 : flush_trg_q);

	// power-off notice is sticky until reset
	always_ff @(posedge clock) begin
		if (rst)
			off_q <= 1'b0;
		else if (poweroff_notified)
			off_q <= 1'b1;
	end

	// enables all drop when the notice is seen and stay off until reset
	always_ff @(posedge clock) begin
		if (rst || poweroff_notified || off_q) begin
			card_event_report_en_q <= 1'b0;
			card_maint_en_q <= 1'b0;
			host_maint_en_q <= 1'b0;
			cache_en_q <= 1'b0;
			command_queue_en_q <= 1'b0;
			command_queue_seq_q <= 1'b0;
		end else begin
			card_event_report_en_q <= evt_en_d;
			card_maint_en_q <= cmaint_en_d;
			host_maint_en_q <= hmaint_en_d;
			cache_en_q <= cache_en_d;
			command_queue_en_q <= cq_en_d;
			command_queue_seq_q <= cq_seq_d;
		end
	end

	// trigger bits; power-off cancels anything running
	always_ff @(posedge clock) begin
		if (rst || poweroff_notified || off_q) begin
			maint_trg_q <= 1'b0;
			flush_trg_q <= 1'b0;
		end else begin
			maint_trg_q <= maint_trg_d;
			flush_trg_q <= flush_trg_d;
		end
	end

	// cycles since the maintenance bit went up
	always_ff @(posedge clock) begin
		if (rst || !maint_trg_q || maint_set)
			maint_cnt_q <= 32'h0;
		else
			maint_cnt_q <= maint_cnt_q + 32'h1;
	end

	// cycles since the flush bit went up
	always_ff @(posedge clock) begin
		if (rst || !flush_trg_q || flush_set)
			flush_cnt_q <= 32'h0;
		else
			flush_cnt_q <= flush_cnt_q + 32'h1;
	end

	// engine reports one cycle late: the handshake sees the bit drop one
	// edge after the report pulse, when that pulse has already gone
	always_ff @(posedge clock) begin
		if (rst) begin
			maint_eng_q <= 1'b0;
			flush_eng_q <= 1'b0;
		end else begin
			maint_eng_q <= maint_broken;
			flush_eng_q <= flush_finished;
		end
	end

	// maintenance engine handshake: one start pulse each time the bit rises,
	// one stop pulse when the bound runs out or power goes away
	always_ff @(posedge clock) begin
		if (rst) begin
			maint_st_q <= PE_TRG_IDLE;
			maint_start_q <= 1'b0;
			maint_stop_q <= 1'b0;
		end else begin
			maint_start_q <= 1'b0;
			maint_stop_q <= 1'b0;
			case (maint_st_q)
				PE_TRG_IDLE: begin
					if (maint_trg_q) begin
						maint_start_q <= 1'b1;
						maint_st_q <= PE_TRG_BUSY;
					end
				end
				PE_TRG_BUSY: begin
					if (!maint_trg_q) begin
						// engine already reported; only tell it on a forced end
						maint_stop_q <= !maint_eng_q;
						maint_st_q <= PE_TRG_DONE;
					end
				end
				PE_TRG_DONE: begin
					maint_st_q <= PE_TRG_IDLE;
				end
				default: begin
					maint_st_q <= PE_TRG_IDLE;
				end
			endcase
		end
	end

	// flush engine handshake, same shape as maintenance
	always_ff @(posedge clock) begin
		if (rst) begin
			flush_st_q <= PE_TRG_IDLE;
			flush_start_q <= 1'b0;
			flush_stop_q <= 1'b0;
		end else begin
			flush_start_q <= 1'b0;
			flush_stop_q <= 1'b0;
			case (flush_st_q)
				PE_TRG_IDLE: begin
					if (flush_trg_q) begin
						flush_start_q <= 1'b1;
						flush_st_q <= PE_TRG_BUSY;
					end
				end
				PE_TRG_BUSY: begin
					if (!flush_trg_q) begin
						flush_stop_q <= !flush_eng_q;
						flush_st_q <= PE_TRG_DONE;
					end
				end
				PE_TRG_DONE: begin
					flush_st_q <= PE_TRG_IDLE;
				end
				default: begin
					flush_st_q <= PE_TRG_IDLE;
				end
			endcase
		end
	end

	// task error store, read one byte at a time
	pe_task_err u_task_err (
		.clock(clock),
		.rst(rst),
		.err_set(task_err_set),
		.err_clr(task_err_clr),
		.rd_idx(acc_addr[2:0]),
		.rd_byte_q(task_byte)
	);

	// first read stage lines up with the store's registered output
	always_ff @(posedge clock) begin
		if (rst) begin
			rd1_q <= 1'b0;
			addr1_q <= 9'h000;
		end else begin
			rd1_q <= acc_rd;
			addr1_q <= acc_addr;
		end
	end

	// read map, support half then control half
	assign rd_byte =
		(addr1_q == PE_OFS_REVISION) ? PE_REVISION_1 :
		(addr1_q == PE_OFS_EVT_SUPPORT) ? {7'h00, evt_supported} :
		(addr1_q == PE_OFS_MAINT_SUPPORT) ?
			{6'h00, host_maint_supported, card_maint_supported} :
		(addr1_q == PE_OFS_CACHE_SUPPORT) ? {7'h00, cache_supported} :
		(addr1_q == PE_OFS_URGENCY) ? {6'h00, maint_urgency} :
		// reserved depth codes are never shown
		(addr1_q == PE_OFS_QUEUE_DEPTH) ?
			((queue_depth_code > PE_DEPTH_MAX) ? PE_ZERO_BYTE
				: queue_depth_code) :
		// store only ever holds 00 or 01
		((addr1_q >= PE_OFS_TASK_ERR_LO) &&
			(addr1_q <= PE_OFS_TASK_ERR_HI)) ? task_byte :
		(addr1_q == PE_OFS_EVT_ENABLE) ?
			{7'h00, card_event_report_en_q} :
		(addr1_q == PE_OFS_MAINT_ENABLE) ?
			{6'h00, host_maint_en_q, card_maint_en_q} :
		// host polls this bit for the break
		(addr1_q == PE_OFS_MAINT_TRIGGER) ? {7'h00, maint_trg_q} :
		(addr1_q == PE_OFS_CACHE_ENABLE) ? {7'h00, cache_en_q} :
		// host polls this bit for flush end
		(addr1_q == PE_OFS_FLUSH_TRIGGER) ? {7'h00, flush_trg_q} :
		(addr1_q == PE_OFS_QUEUE_CONTROL) ?
			{6'h00, command_queue_seq_q, command_queue_en_q} :
		PE_ZERO_BYTE;

	// read answer two edges after the strobe; data held until next read
	always_ff @(posedge clock) begin
		if (rst) begin
			acc_rdata_q <= PE_ZERO_BYTE;
			acc_rvalid_q <= 1'b0;
		end else begin
			acc_rvalid_q <= rd1_q;
			if (rd1_q)
				acc_rdata_q <= rd_byte;
		end
	end

endmodule

`default_nettype wire

// ==== hw/pe_pkg.sv ====
// pe_pkg: offsets, field positions, reset values and timing counts for
// the performance enhancement extension register set.
// assumes a 250 MHz core clock and byte-wide register access.
`default_nettype none

package pe_pkg;

	// byte offsets inside the 512-byte register set
	localparam logic [8:0] PE_OFS_REVISION = 9'h000;
	localparam logic [8:0] PE_OFS_EVT_SUPPORT = 9'h001;
	localparam logic [8:0] PE_OFS_MAINT_SUPPORT = 9'h002;
	localparam logic [8:0] PE_OFS_URGENCY = 9'h003;
	localparam logic [8:0] PE_OFS_CACHE_SUPPORT = 9'h004;
	localparam logic [8:0] PE_OFS_QUEUE_DEPTH = 9'h006;
	localparam logic [8:0] PE_OFS_TASK_ERR_LO = 9'h008;
	localparam logic [8:0] PE_OFS_TASK_ERR_HI = 9'h00F;
	localparam logic [8:0] PE_OFS_EVT_ENABLE = 9'h101;
	localparam logic [8:0] PE_OFS_MAINT_ENABLE = 9'h102;
	localparam logic [8:0] PE_OFS_MAINT_TRIGGER = 9'h103;
	localparam logic [8:0] PE_OFS_CACHE_ENABLE = 9'h104;
	localparam logic [8:0] PE_OFS_FLUSH_TRIGGER = 9'h105;
	localparam logic [8:0] PE_OFS_QUEUE_CONTROL = 9'h106;

	// the top address bit splits support bytes from control bytes
	localparam int PE_CTRL_BIT = 8;

	// field positions
	localparam int PE_BIT_CARD_MAINT = 0;
	localparam int PE_BIT_HOST_MAINT = 1;
	localparam int PE_BIT_QUEUE_EN = 0;
	localparam int PE_BIT_QUEUE_SEQ = 1;
	localparam int PE_BIT_TRIGGER = 0;
	localparam int PE_BIT_ENABLE = 0;

	// fixed values
	localparam logic [7:0] PE_REVISION_1 = 8'h00;
	localparam logic [7:0] PE_ZERO_BYTE = 8'h00;
	localparam logic [7:0] PE_DEPTH_MAX = 8'h1F;
	localparam logic [1:0] PE_TASK_OK = 2'h0;
	localparam logic [1:0] PE_TASK_ERROR = 2'h1;
	localparam int PE_TASKS = 32;

	// break-off bound for host maintenance and cache flush
	localparam longint PE_BOUND_NS = 1000000000;
	localparam longint PE_CLK_PERIOD_NS = 4;
	// longest time: round down to whole cycles
	localparam int unsigned PE_BOUND_CYCLES =
		int'(PE_BOUND_NS / PE_CLK_PERIOD_NS);

	// trigger tracking states
	typedef enum logic [1:0] {
		PE_TRG_IDLE = 2'b00,
		PE_TRG_BUSY = 2'b01,
		PE_TRG_DONE = 2'b10
	} pe_trg_e;

endpackage

`default_nettype wire

// ==== hw/pe_task_err.sv ====
// pe_task_err: per-task 2-bit error status for 32 queued task ids,
// with a registered byte read port (four tasks per byte).
// assumes set and clear pulses come from queue logic on the same clock.
`default_nettype none

module pe_task_err
	import pe_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [31:0] err_set,
	input wire logic [31:0] err_clr,
	input wire logic [2:0] rd_idx,
	output logic [7:0] rd_byte_q
);

	logic [1:0] status_q [PE_TASKS];
	logic [63:0] flat;

	// one status field per task; an error arriving with its clear wins
	for (genvar t = 0; t < PE_TASKS; t++) begin : g_task
		always_ff @(posedge clock) begin
			if (rst)
				status_q[t] <= PE_TASK_OK;
			else if (err_set[t])
				status_q[t] <= PE_TASK_ERROR;
			else if (err_clr[t])
				status_q[t] <= PE_TASK_OK;
		end
		assign flat[2*t +: 2] = status_q[t];
	end

	// task 0 sits in the low bits of the first byte
	always_ff @(posedge clock) begin
		if (rst)
			rd_byte_q <= PE_ZERO_BYTE;
		else
			rd_byte_q <= flat[{rd_idx, 3'b000} +: 8];
	end

endmodule

`default_nettype wire

// ==== test/pe_regs_props.sv ====
// pe_regs_chk: port-level timing and value checks for the register set.
// assumes byte access as handed over and a short break-off bound.
`default_nettype none
module pe_regs_chk
	import pe_pkg::*;
#(
	parameter int unsigned BOUND_CYCLES = 20
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire logic [8:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	input wire logic [7:0] acc_rdata_q,
	input wire logic acc_rvalid_q,
	input wire logic evt_supported,
	input wire logic [1:0] maint_urgency,
	input wire logic maint_broken,
	input wire logic flush_finished,
	input wire logic poweroff_notified,
	input wire logic card_event_report_en_q,
	input wire logic card_maint_en_q,
	input wire logic host_maint_en_q,
	input wire logic cache_en_q,
	input wire logic command_queue_en_q,
	input wire logic maint_start_q,
	input wire logic maint_stop_q,
	input wire logic flush_start_q,
	input wire logic flush_stop_q
);
	// slack of a few cycles covers the set and stop pipeline
	localparam int LIM = BOUND_CYCLES + 4;
	logic po_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// the power-off notice blocks writes until reset
	always_ff @(posedge clock) begin
		if (rst)
			po_q <= 1'b0;
		else if (poweroff_notified)
			po_q <= 1'b1;
	end
	rd_answer_a: assert property (acc_rd |-> ##2 acc_rvalid_q)
		else $error("read answer missing");
	rd_only_a: assert property (acc_rvalid_q |-> $past(acc_rd, 2))
		else $error("read answer without read");
	rev_value_a: assert property (acc_rd && acc_addr == 9'h000
		|-> ##2 acc_rdata_q == 8'h00) else $error("revision wrong");
	evt_support_a: assert property (acc_rd && acc_addr == 9'h001
		|-> ##2 acc_rdata_q == {7'h00, $past(evt_supported, 2)})
		else $error("event support byte wrong");
	urgency_byte_a: assert property (acc_rd && acc_addr == 9'h003
		|-> ##2 acc_rdata_q == {6'h00, $past(maint_urgency, 2)})
		else $error("urgency byte wrong");
	task_codes_a: assert property (acc_rd && acc_addr[8:3] == 6'h01
		|-> ##2 (acc_rdata_q & 8'hAA) == 8'h00)
		else $error("reserved task code seen");
	evt_enable_a: assert property (acc_wr && acc_addr == 9'h101 &&
		!po_q && !poweroff_notified
		|=> card_event_report_en_q == $past(acc_wdata[0]))
		else $error("event enable not written");
	maint_enable_a: assert property (acc_wr && acc_addr == 9'h102 &&
		!po_q && !poweroff_notified
		|=> {host_maint_en_q, card_maint_en_q} == $past(acc_wdata[1:0]))
		else $error("maintenance enables not written");
	maint_bound_a: assert property (maint_start_q
		|-> ##[1:LIM] (maint_broken || maint_stop_q))
		else $error("maintenance not broken off in time");
	flush_bound_a: assert property (flush_start_q
		|-> ##[1:LIM] (flush_finished || flush_stop_q))
		else $error("flush not ended in time");
	poweroff_off_a: assert property (poweroff_notified |=>
		!(card_event_report_en_q || card_maint_en_q || host_maint_en_q ||
		cache_en_q || command_queue_en_q)) else $error("feature left on");
	maint_start_c: cover property (maint_start_q);
	flush_stop_c: cover property (flush_stop_q);
	poweroff_c: cover property (poweroff_notified);
endmodule
bind pe_regs pe_regs_chk #(.BOUND_CYCLES(BOUND_CYCLES)) i_chk (
	.clock(clock), .rst(rst), .acc_wr(acc_wr), .acc_rd(acc_rd),
	.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata_q(acc_rdata_q),
	.acc_rvalid_q(acc_rvalid_q), .evt_supported(evt_supported),
	.maint_urgency(maint_urgency), .maint_broken(maint_broken),
	.flush_finished(flush_finished), .poweroff_notified(poweroff_notified),
	.card_event_report_en_q(card_event_report_en_q),
	.card_maint_en_q(card_maint_en_q), .host_maint_en_q(host_maint_en_q),
	.cache_en_q(cache_en_q), .command_queue_en_q(command_queue_en_q),
	.maint_start_q(maint_start_q), .maint_stop_q(maint_stop_q),
	.flush_start_q(flush_start_q), .flush_stop_q(flush_stop_q));
`default_nettype wire

// ==== test/pe_host_model.sv ====
// pe_host_model: host side issuing byte reads and writes to the set.
// assumes one request at a time and an answer within a few edges.
`default_nettype none
module pe_host_model (
	input wire logic clock,
	input wire logic [7:0] acc_rdata_q,
	input wire logic acc_rvalid_q,
	output logic acc_wr,
	output logic acc_rd,
	output logic [8:0] acc_addr,
	output logic [7:0] acc_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle lines show junk, never a stale request
	initial begin
		acc_wr = 1'b0;
		acc_rd = 1'b0;
		acc_addr = 9'h1FF;
		acc_wdata = 8'hA5;
	end
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clock);
		acc_wr <= 1'b1;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge clock);
		acc_wr <= 1'b0;
		acc_addr <= ~a;
		acc_wdata <= ~d;
	endtask
	// data is taken at the edge where valid is seen high
	task automatic rd(input logic [8:0] a, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clock);
		acc_rd <= 1'b1;
		acc_addr <= a;
		@(posedge clock);
		acc_rd <= 1'b0;
		acc_addr <= ~a;
		for (int n = 0; n < 4 && !ok; n++) begin
			@(posedge clock);
			ok = (acc_rvalid_q === 1'b1);
			d = acc_rdata_q;
		end
	endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// tb: drives the register set through the host model and judges replies.
// assumes a short break-off bound so forced ends come quickly.
`default_nettype none
module tb
	import pe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BOUND = 20;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic acc_wr, acc_rd, acc_rvalid_q, broken = 1'b0, finished = 1'b0;
	logic [8:0] acc_addr;
	logic [7:0] acc_wdata, acc_rdata_q, depth = 8'h1F;
	logic [1:0] urg = 2'h0;
	logic [31:0] e_set = 32'h0, e_clr = 32'h0;
	logic po = 1'b0;
	logic [5:0] en;
	logic m_start, m_stop, f_start, f_stop;
	int fails = 0;
	int checked = 0;
	always #2 clock = ~clock;
	pe_host_model i_host (.clock(clock), .acc_rdata_q(acc_rdata_q),
		.acc_rvalid_q(acc_rvalid_q), .acc_wr(acc_wr), .acc_rd(acc_rd),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata));
	pe_regs #(.BOUND_CYCLES(BOUND)) i_dut (.clock(clock), .rst(rst),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_rdata_q(acc_rdata_q),
		.acc_rvalid_q(acc_rvalid_q), .evt_supported(1'b1),
		.card_maint_supported(1'b1), .host_maint_supported(1'b1),
		.cache_supported(1'b1), .maint_urgency(urg),
		.queue_depth_code(depth), .task_err_set(e_set),
		.task_err_clr(e_clr), .maint_broken(broken),
		.flush_finished(finished), .poweroff_notified(po),
		.card_event_report_en_q(en[5]), .card_maint_en_q(en[4]),
		.host_maint_en_q(en[3]), .cache_en_q(en[2]),
		.command_queue_en_q(en[1]), .command_queue_seq_q(en[0]),
		.maint_start_q(m_start), .maint_stop_q(m_stop),
		.flush_start_q(f_start), .flush_stop_q(f_stop));
	task automatic give_verdict();
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// a read that never answers ends the run at once
	task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		i_host.rd(a, d, ok);
		chk("read answer", 8'h01, {7'h00, ok});
		if (!ok)
			give_verdict();
		chk($sformatf("byte %h", a), exp, d);
	endtask
	task automatic t_support();
		rdc(PE_OFS_REVISION, 8'h00);
		rdc(PE_OFS_EVT_SUPPORT, 8'h01);
		rdc(PE_OFS_MAINT_SUPPORT, 8'h03);
		rdc(PE_OFS_CACHE_SUPPORT, 8'h01);
		for (int u = 0; u < 4; u++) begin
			@(posedge clock);
			urg <= u[1:0];
			rdc(PE_OFS_URGENCY, {6'h00, u[1:0]});
		end
		i_host.wr(PE_OFS_QUEUE_DEPTH, 8'h05);
		rdc(PE_OFS_QUEUE_DEPTH, 8'h1F);
		@(posedge clock);
		depth <= 8'h20;
		rdc(PE_OFS_QUEUE_DEPTH, 8'h00);
		rdc(9'h005, 8'h00);
		rdc(9'h1FF, 8'h00);
	endtask
	task automatic t_task_err();
		@(posedge clock);
		e_set <= 32'h80000021;
		@(posedge clock);
		e_set <= 32'h0;
		rdc(9'h008, 8'h01);
		rdc(9'h009, 8'h04);
		rdc(9'h00F, 8'h40);
		@(posedge clock);
		e_clr <= 32'h00000001;
		@(posedge clock);
		e_clr <= 32'h0;
		rdc(9'h008, 8'h00);
	endtask
	// all-ones writes prove that reserved bits stay clear
	task automatic t_enables();
		i_host.wr(PE_OFS_EVT_ENABLE, 8'hFF);
		i_host.wr(PE_OFS_MAINT_ENABLE, 8'hFF);
		i_host.wr(PE_OFS_CACHE_ENABLE, 8'hFF);
		i_host.wr(PE_OFS_QUEUE_CONTROL, 8'hFF);
		rdc(PE_OFS_EVT_ENABLE, 8'h01);
		rdc(PE_OFS_MAINT_ENABLE, 8'h03);
		rdc(PE_OFS_CACHE_ENABLE, 8'h01);
		rdc(PE_OFS_QUEUE_CONTROL, 8'h03);
		chk("enables", 8'h3F, {2'h0, en});
		i_host.wr(PE_OFS_QUEUE_CONTROL, 8'h01);
		rdc(PE_OFS_QUEUE_CONTROL, 8'h01);
	endtask
	// a trigger ends either by the engine or by the break-off bound
	task automatic t_trig(input logic [8:0] a, input logic by_engine);
		logic seen;
		logic is_m;
		is_m = (a == PE_OFS_MAINT_TRIGGER);
		seen = 1'b0;
		i_host.wr(a, 8'h01);
		for (int n = 0; n < 6 && !seen; n++) begin
			@(posedge clock);
			seen = is_m ? m_start : f_start;
		end
		chk("start pulse", 8'h01, {7'h00, seen});
		if (by_engine) begin
			broken <= is_m;
			finished <= !is_m;
			@(posedge clock);
			broken <= 1'b0;
			finished <= 1'b0;
			// an engine-reported end must not raise a forced stop
			seen = 1'b0;
			for (int n = 0; n < 4; n++) begin
				@(posedge clock);
				seen = seen | (is_m ? m_stop : f_stop);
			end
			chk("stop after engine end", 8'h00, {7'h00, seen});
		end else begin
			seen = 1'b0;
			for (int n = 0; n < BOUND + 8 && !seen; n++) begin
				@(posedge clock);
				seen = is_m ? m_stop : f_stop;
			end
			chk("forced stop", 8'h01, {7'h00, seen});
			if (!seen)
				give_verdict();
		end
		rdc(a, 8'h00);
	endtask
	task automatic t_poweroff();
		@(posedge clock);
		po <= 1'b1;
		@(posedge clock);
		po <= 1'b0;
		@(posedge clock);
		chk("enables off", 8'h00, {2'h0, en});
		i_host.wr(PE_OFS_CACHE_ENABLE, 8'h01);
		rdc(PE_OFS_CACHE_ENABLE, 8'h00);
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_support();
		t_task_err();
		t_enables();
		t_trig(PE_OFS_MAINT_TRIGGER, 1'b1);
		t_trig(PE_OFS_FLUSH_TRIGGER, 1'b1);
		t_trig(PE_OFS_MAINT_TRIGGER, 1'b0);
		t_trig(PE_OFS_FLUSH_TRIGGER, 1'b0);
		t_poweroff();
		give_verdict();
	end
endmodule
`default_nettype wire
